// ### hw/fm_fault_bank.sv
// Sticky fault status bank with clear-on-read and voltage-identification register.
// Assumes the serial port engine gives one-cycle read and write strobes with an address,
// and that all measurement results and limits arrive synchronous to i_ref_clk.
`timescale 1ns/1ns
// What this block does
// R01 - Supply faults when reading <= low or > high
// R02 - Primary status register layout, reset zero
// R03 - Secondary status register layout, reset zero
// R04 - Status bits stay set until read
// R05 - Read clears bits whose fault disappeared
// R06 - Host writes to these registers ignored
// R07 - Independent faults each set own bit
// R08 - Primary bit 7 summarizes secondary register
// R09 - Zone one from first diode or fault
// R10 - Zone two from on-die temperature window
// R11 - Zone three from second diode window
// R12 - Fan stall when tach exceeds minimum
// R13 - First diode open sets bits 6, 4
// R14 - Second diode open sets bits 7, 6
// R15 - Twelve volt window fault bit
// R16 - Read-only register shows five identification pins
// R17 - No stall when duty zero or disabled
// R18 - All-ones minimum suppresses stall except timeout
// R19 - Set wins over same-cycle clear
// R20 - Host polls status, uses identification value
module fm_fault_bank
	import fm_pkg::*;
#(
	parameter int VOLT_W = FM_VOLT_W,
	parameter int TEMP_W = FM_TEMP_W,
	parameter int TACH_W = FM_TACH_W
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Register port from the serial engine
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_hit,
	// Supply readings and limits, index order 2.5V, core, 3.3V, 5V, 12V
	input wire logic [FM_NUM_SUPPLY*VOLT_W-1:0] i_supply_reading,
	input wire logic [FM_NUM_SUPPLY*VOLT_W-1:0] i_supply_low_limit,
	input wire logic [FM_NUM_SUPPLY*VOLT_W-1:0] i_supply_high_limit,
	// Zone temperatures and limits, index order zone 1, 2, 3
	input wire logic [FM_NUM_ZONE*TEMP_W-1:0] i_zone_temp,
	input wire logic [FM_NUM_ZONE*TEMP_W-1:0] i_zone_low_limit,
	input wire logic [FM_NUM_ZONE*TEMP_W-1:0] i_zone_high_limit,
	// Remote diode faults
	input wire logic i_remote_diode_a_open,
	input wire logic i_remote_diode_a_short,
	input wire logic i_remote_diode_b_open,
	// Fan tachometer results and control state
	input wire logic [FM_NUM_FAN*TACH_W-1:0] i_tach_period,
	input wire logic [FM_NUM_FAN*TACH_W-1:0] i_tach_min_count,
	input wire logic [FM_NUM_FAN*FM_DUTY_W-1:0] i_fan_duty,
	input wire logic [FM_NUM_FAN-1:0] i_fan_enable,
	input wire logic [FM_NUM_FAN-1:0] i_tach_timeout,
	// Voltage identification pins
	input wire logic [FM_VID_W-1:0] i_volt_ident_pin,
	// Status view
	output logic [7:0] o_fault_status_primary,
	output logic [7:0] o_fault_status_secondary
);
	// ************************************************************
	// Live fault conditions
	// ************************************************************
	logic [FM_NUM_SUPPLY-1:0] supply_fault;
	logic [FM_NUM_ZONE-1:0] zone_window_fault;
	logic [FM_NUM_FAN-1:0] fan_stall_cond;
	logic zone_one_fault;
	logic zone_two_fault;
	logic zone_three_fault;
	logic remote_diode_a_open;
	logic remote_diode_b_open;

	genvar gi;
	generate
		for (gi = 0; gi < FM_NUM_SUPPLY; gi++)
		begin : g_supply
			fm_limit_cmp #(
				.WIDTH(VOLT_W),
				.SIGNED_CMP(1'b0)
			) u_cmp (
				.i_reading(i_supply_reading[gi*VOLT_W +: VOLT_W]),
				.i_low_limit(i_supply_low_limit[gi*VOLT_W +: VOLT_W]),
				.i_high_limit(i_supply_high_limit[gi*VOLT_W +: VOLT_W]),
				.o_out_of_window(supply_fault[gi])
			); // R01 R15
		end
		// Temperatures are two's complement
		for (gi = 0; gi < FM_NUM_ZONE; gi++)
		begin : g_zone
			fm_limit_cmp #(
				.WIDTH(TEMP_W),
				.SIGNED_CMP(1'b1)
			) u_cmp (
				.i_reading(i_zone_temp[gi*TEMP_W +: TEMP_W]),
				.i_low_limit(i_zone_low_limit[gi*TEMP_W +: TEMP_W]),
				.i_high_limit(i_zone_high_limit[gi*TEMP_W +: TEMP_W]),
				.o_out_of_window(zone_window_fault[gi])
			);
		end
		for (gi = 0; gi < FM_NUM_FAN; gi++)
		begin : g_fan
			logic [TACH_W-1:0] period;
			logic [TACH_W-1:0] min_count;
			logic fan_active;
			logic no_limit;
			assign period = i_tach_period[gi*TACH_W +: TACH_W];
			assign min_count = i_tach_min_count[gi*TACH_W +: TACH_W];
			// Stopped or disabled fans never report a stall
			assign fan_active = i_fan_enable[gi]
				& (i_fan_duty[gi*FM_DUTY_W +: FM_DUTY_W] != FM_DUTY_OFF); // R17
			assign no_limit = (min_count == FM_TACH_NO_LIMIT[TACH_W-1:0]); // R18
			assign fan_stall_cond[gi] = fan_active
				& (((period > min_count) & ~no_limit) | i_tach_timeout[gi]); // R12 R18
		end
	endgenerate

	assign remote_diode_a_open = i_remote_diode_a_open;
	assign remote_diode_b_open = i_remote_diode_b_open;
	// Diode faults fold into their zone bits
	assign zone_one_fault = zone_window_fault[0] | remote_diode_a_open
		| i_remote_diode_a_short; // R09 R13
	assign zone_two_fault = zone_window_fault[1]; // R10
	assign zone_three_fault = zone_window_fault[2] | remote_diode_b_open; // R11 R14

	// ************************************************************
	// Condition vectors in register layout
	// ************************************************************
	logic [6:0] pri_cond;
	logic [7:0] sec_cond;

	assign pri_cond[FM_PRI_V2P5] = supply_fault[FM_SUP_V2P5];
	assign pri_cond[FM_PRI_VCORE] = supply_fault[FM_SUP_VCORE];
	assign pri_cond[FM_PRI_V3P3] = supply_fault[FM_SUP_V3P3];
	assign pri_cond[FM_PRI_V5] = supply_fault[FM_SUP_V5];
	assign pri_cond[FM_PRI_ZONE1] = zone_one_fault;
	assign pri_cond[FM_PRI_ZONE2] = zone_two_fault;
	assign pri_cond[FM_PRI_ZONE3] = zone_three_fault; // R02

	assign sec_cond[FM_SEC_V12] = supply_fault[FM_SUP_V12]; // R15
	assign sec_cond[FM_SEC_RES] = 1'b0; // R03
	assign sec_cond[FM_SEC_FAN_LSB +: FM_NUM_FAN] = fan_stall_cond;
	assign sec_cond[FM_SEC_DIODE_A] = remote_diode_a_open; // R13
	assign sec_cond[FM_SEC_DIODE_B] = remote_diode_b_open; // R14

	// ************************************************************
	// Register decode
	// ************************************************************
	logic sel_pri;
	logic sel_sec;
	logic sel_vid;
	logic rd_pri;
	logic rd_sec;

	assign sel_pri = (i_reg_addr == FM_ADDR_STATUS_PRI);
	assign sel_sec = (i_reg_addr == FM_ADDR_STATUS_SEC);
	assign sel_vid = (i_reg_addr == FM_ADDR_VOLT_ID);
	assign rd_pri = i_reg_rd & sel_pri;
	assign rd_sec = i_reg_rd & sel_sec;
	// Writes are decoded only to report a hit; no storage listens to them
	assign o_reg_hit = (i_reg_rd | i_reg_wr) & (sel_pri | sel_sec | sel_vid); // R06

	// ************************************************************
	// Sticky status storage
	// ************************************************************
	logic [6:0] pri_q;
	logic [6:0] pri_d;
	logic [7:0] sec_q;
	logic [7:0] sec_d;
	logic summary;

	// Read returns the old value; the clear lands on the same edge,
	// but any live condition sets again so no event is lost
	assign pri_d = pri_cond | (pri_q & ~{7{rd_pri}}); // R04 R05 R07 R19
	assign sec_d = sec_cond | (sec_q & ~{8{rd_sec}}); // R04 R05 R07 R19

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pri_q <= FM_RST_STATUS_PRI[6:0]; // R02
			sec_q <= FM_RST_STATUS_SEC; // R03
		end
		else
		begin
			pri_q <= pri_d;
			sec_q <= sec_d;
		end
	end

	// Summary tracks the stored secondary bits, so it clears with them
	assign summary = |sec_q; // R08

	// ************************************************************
	// Voltage identification capture
	// ************************************************************
	logic [FM_VID_W-1:0] vid_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			vid_q <= FM_RST_VOLT_ID[FM_VID_W-1:0]; // R16
		else
			vid_q <= i_volt_ident_pin; // R16
	end

	// ************************************************************
	// Read data
	// ************************************************************
	logic [7:0] pri_view;
	logic [7:0] sec_view;
	logic [7:0] vid_view;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;

	assign pri_view = {summary, pri_q}; // R02 R08
	assign sec_view = {sec_q[7:2], 1'b0, sec_q[FM_SEC_V12]}; // R03
	assign vid_view = {{(8 - FM_VID_W){1'b0}}, vid_q}; // R16
	// Unmapped addresses read as zero
	assign rdata_d = sel_pri ? pri_view
		: sel_sec ? sec_view
		: sel_vid ? vid_view
		: 8'h00;

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata_q <= FM_RST_RDATA;
		else if (i_reg_rd)
			rdata_q <= rdata_d;
	end

	assign o_reg_rdata = rdata_q;
	assign o_fault_status_primary = pri_view;
	assign o_fault_status_secondary = sec_view;

	// Write data is deliberately unused: every register here is read-only
	logic unused_wdata;
	assign unused_wdata = ^i_reg_wdata; // R06
endmodule // fm_fault_bank

// ### hw/fm_limit_cmp.sv
// Window comparator for one measured value against its low and high limit.
// Assumes reading and limits are stable in the same cycle; result is combinational.
`timescale 1ns/1ns
module fm_limit_cmp #(
	parameter int WIDTH = 8,
	parameter bit SIGNED_CMP = 1'b0
) (
	// Value and window
	input wire logic [WIDTH-1:0] i_reading,
	input wire logic [WIDTH-1:0] i_low_limit,
	input wire logic [WIDTH-1:0] i_high_limit,
	// Result
	output logic o_out_of_window
);
	logic at_or_below_low;
	logic above_high;

	// Low limit is inclusive, high limit is exclusive
	assign at_or_below_low = SIGNED_CMP ? ($signed(i_reading) <= $signed(i_low_limit))
		: (i_reading <= i_low_limit);
	assign above_high = SIGNED_CMP ? ($signed(i_reading) > $signed(i_high_limit))
		: (i_reading > i_high_limit);
	assign o_out_of_window = at_or_below_low | above_high;
endmodule // fm_limit_cmp

// ### hw/fm_pkg.sv
// Package for the monitor fault status bank: offsets, bit positions and resets.
// Assumes an 8-bit register address space reached through the serial port engine.
package fm_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] FM_ADDR_STATUS_PRI = 8'h41;
	localparam logic [7:0] FM_ADDR_STATUS_SEC = 8'h42;
	localparam logic [7:0] FM_ADDR_VOLT_ID = 8'h43;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] FM_RST_STATUS_PRI = 8'h00;
	localparam logic [7:0] FM_RST_STATUS_SEC = 8'h00;
	localparam logic [7:0] FM_RST_VOLT_ID = 8'h00;
	localparam logic [7:0] FM_RST_RDATA = 8'h00;

	// ************************************************************
	// Primary status bit positions
	// ************************************************************
	localparam int FM_PRI_V2P5 = 0;
	localparam int FM_PRI_VCORE = 1;
	localparam int FM_PRI_V3P3 = 2;
	localparam int FM_PRI_V5 = 3;
	localparam int FM_PRI_ZONE1 = 4;
	localparam int FM_PRI_ZONE2 = 5;
	localparam int FM_PRI_ZONE3 = 6;
	localparam int FM_PRI_SUMMARY = 7;

	// ************************************************************
	// Secondary status bit positions
	// ************************************************************
	localparam int FM_SEC_V12 = 0;
	localparam int FM_SEC_RES = 1;
	localparam int FM_SEC_FAN_LSB = 2;
	localparam int FM_SEC_DIODE_A = 6;
	localparam int FM_SEC_DIODE_B = 7;

	// ************************************************************
	// Field widths and special values
	// ************************************************************
	localparam int FM_NUM_SUPPLY = 5;
	localparam int FM_NUM_ZONE = 3;
	localparam int FM_NUM_FAN = 4;
	localparam int FM_VID_W = 5;
	localparam int FM_VOLT_W = 8;
	localparam int FM_TEMP_W = 10;
	localparam int FM_TACH_W = 16;
	localparam int FM_DUTY_W = 8;
	localparam logic [15:0] FM_TACH_NO_LIMIT = 16'hFFFF;
	localparam logic [7:0] FM_DUTY_OFF = 8'h00;

	// Supply index order inside the packed reading vectors
	localparam int FM_SUP_V2P5 = 0;
	localparam int FM_SUP_VCORE = 1;
	localparam int FM_SUP_V3P3 = 2;
	localparam int FM_SUP_V5 = 3;
	localparam int FM_SUP_V12 = 4;
endpackage

// ### tb/fm_fault_bank_chk.sv
// Port checker for the fault status bank.
// Assumes binding onto fm_fault_bank; sees its ports only.
`timescale 1ns/1ns
module fm_fault_bank_chk
	import fm_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_reg_hit,
	// Fault sources and status
	input wire logic i_remote_diode_a_open,
	input wire logic i_remote_diode_a_short,
	input wire logic i_remote_diode_b_open,
	input wire logic [FM_VID_W-1:0] i_volt_ident_pin,
	input wire logic [7:0] o_fault_status_primary,
	input wire logic [7:0] o_fault_status_secondary
);
	wire [7:0] pri = o_fault_status_primary;
	wire [7:0] sec = o_fault_status_secondary;
	wire rd_pri = i_reg_rd && i_reg_addr == FM_ADDR_STATUS_PRI;
	wire rd_vid = i_reg_rd && i_reg_addr == FM_ADDR_VOLT_ID;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// ********************
	// Checks
	// ********************
	chk_summary_bit: assert property (pri[7] == |sec)
		else $error("summary bit wrong");
	chk_res_zero: assert property (!sec[1])
		else $error("reserved bit set");
	chk_diode_a_open: assert property (i_remote_diode_a_open |=> sec[6] && pri[4])
		else $error("diode a open missed");
	chk_diode_b_open: assert property (i_remote_diode_b_open |=> sec[7] && pri[6])
		else $error("diode b open missed");
	chk_short_zone: assert property (i_remote_diode_a_short |=> pri[4])
		else $error("diode short missed");
	// Past values read zero in reset, so no false hit after release
	chk_sticky_hold: assert property (!rd_pri |=> (pri[6:0] & $past(pri[6:0])) == $past(pri[6:0]))
		else $error("status bit lost");
	chk_read_data: assert property (rd_pri |=> o_reg_rdata == $past(pri))
		else $error("primary read data wrong");
	chk_vid_read: assert property (rd_vid && $stable(i_volt_ident_pin) && $past(i_rst_n)
		|=> o_reg_rdata == {3'h0, $past(i_volt_ident_pin)})
		else $error("identification read wrong");
	chk_write_quiet: assert property (i_reg_wr && !i_reg_rd |=> $stable(o_reg_rdata))
		else $error("write changed read data");
	chk_hit_decode: assert property (o_reg_hit == ((i_reg_rd || i_reg_wr)
		&& i_reg_addr inside {[FM_ADDR_STATUS_PRI:FM_ADDR_VOLT_ID]}))
		else $error("hit decode wrong");
	cover property (rd_pri && pri[3:0] != 4'h0);
	cover property (i_reg_rd && i_reg_addr == FM_ADDR_STATUS_SEC && sec[5:2] != 4'h0);
	cover property (i_remote_diode_b_open);
endmodule // fm_fault_bank_chk

bind fm_fault_bank fm_fault_bank_chk u_fm_fault_bank_chk (.i_ref_clk, .i_rst_n,
	.i_reg_addr, .i_reg_rd, .i_reg_wr, .o_reg_rdata, .o_reg_hit, .i_remote_diode_a_open,
	.i_remote_diode_a_short, .i_remote_diode_b_open, .i_volt_ident_pin,
	.o_fault_status_primary, .o_fault_status_secondary);

// ### tb/fm_fault_bank_tb_top.sv
// Testbench for the fault status bank with a host model.
// Assumes the package constants and a 25 MHz clock.
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR %s exp %h got %h", n, e, a); end end
module fm_fault_bank_tb_top
	import fm_pkg::*;
;
	logic clk, rst_n, rd, wr, a_open, a_short, b_open, hit;
	logic [7:0] addr, wdata, rdata, pri, sec, d;
	logic [39:0] sr, sl, sh;
	logic [29:0] zt, zl, zh;
	logic [63:0] tp, tm;
	logic [31:0] duty, lfsr;
	logic [3:0] fen, tto;
	logic [4:0] vid;
	int n_errors = 0;
	int total_checks = 0;
	logic [7:0] sv[4] = '{8'h10, 8'hF1, 8'hF0, 8'h11};
	logic [9:0] zv[4] = '{10'h39C, 10'h065, 10'h064, 10'h39D};
	logic [15:0] dv[3] = '{16'h9040, 16'h1000, 16'hC080};
	fm_fault_bank u_fm_fault_bank (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr),
		.i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_reg_hit(hit), .i_supply_reading(sr), .i_supply_low_limit(sl),
		.i_supply_high_limit(sh), .i_zone_temp(zt), .i_zone_low_limit(zl),
		.i_zone_high_limit(zh), .i_remote_diode_a_open(a_open),
		.i_remote_diode_a_short(a_short), .i_remote_diode_b_open(b_open),
		.i_tach_period(tp), .i_tach_min_count(tm), .i_fan_duty(duty), .i_fan_enable(fen),
		.i_tach_timeout(tto), .i_volt_ident_pin(vid), .o_fault_status_primary(pri),
		.o_fault_status_secondary(sec));
	fm_host_model u_fm_host_model (.i_ref_clk(clk), .o_reg_addr(addr), .o_reg_rd(rd),
		.o_reg_wr(wr), .o_reg_wdata(wdata), .i_reg_rdata(rdata));
	// ********************
	// Helpers
	// ********************
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Supply fault mask to expected primary and secondary
	function automatic logic [15:0] exp_supply(input logic [4:0] m);
		return {m[4], 3'h0, m[3:0], 7'h00, m[4]};
	endfunction
	task automatic quiet();
		sr = {5{8'h80}};
		sl = {5{8'h10}};
		sh = {5{8'hF0}};
		zt = '0;
		zl = {3{10'h39C}};
		zh = {3{10'h064}};
		{a_open, a_short, b_open} = 3'h0;
		tp = {4{16'h1000}};
		tm = {4{16'h2000}};
		duty = {4{8'h80}};
		fen = 4'hF;
		tto = 4'h0;
	endtask
	task automatic pulse();
		@(posedge clk);
		#1;
		quiet();
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		u_fm_host_model.access(a, 1'b0, 8'h00, 0, d);
		`CHK("rdata", e, d)
	endtask
	// Secondary read before the second primary read, since the summary clears last
	task automatic expect_flags(input logic [15:0] ps);
		rd_chk(FM_ADDR_STATUS_PRI, ps[15:8]);
		rd_chk(FM_ADDR_STATUS_SEC, ps[7:0]);
		rd_chk(FM_ADDR_STATUS_PRI, 8'h00);
		rd_chk(FM_ADDR_STATUS_SEC, 8'h00);
	endtask
	task automatic final_report();
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#400000;
		n_errors++;
		final_report();
	end
	// ********************
	// Scenarios
	// ********************
	initial
	begin
		quiet();
		lfsr = 32'h62DF;
		vid = 5'h00;
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		vid = lfsr[4:0];
		rd_chk(FM_ADDR_STATUS_PRI, FM_RST_STATUS_PRI);
		rd_chk(FM_ADDR_STATUS_SEC, FM_RST_STATUS_SEC);
		rd_chk(FM_ADDR_VOLT_ID, {3'h0, vid});
		for (int i = 0; i < 8; i++)
			for (int j = 0; j < 4; j++)
			begin
				if (i < 5)
					sr[i*8 +: 8] = sv[j];
				else
					zt[(i-5)*10 +: 10] = zv[j];
				pulse();
				expect_flags(j > 1 ? 16'h0 : i < 5 ? exp_supply(5'(1 << i))
					: {8'(8'h10 << (i - 5)), 8'h00});
			end
		for (int i = 0; i < 3; i++)
		begin
			{a_open, a_short, b_open} = 3'h4 >> i;
			pulse();
			expect_flags(dv[i]);
		end
		for (int f = 0; f < 4; f++)
			for (int j = 0; j < 6; j++)
			begin
				tp[f*16 +: 16] = (j == 5) ? 16'h2000 : 16'hFFFF;
				duty[f*8 +: 8] = (j == 1) ? FM_DUTY_OFF : 8'h80;
				fen[f] = (j != 2);
				tm[f*16 +: 16] = (j == 3 || j == 4) ? FM_TACH_NO_LIMIT : 16'h2000;
				tto[f] = (j == 4);
				pulse();
				expect_flags((j == 0 || j == 4) ? {8'h80, 8'h04 << f} : 16'h0);
			end
		repeat (20)
		begin
			lfsr = next_rand(lfsr);
			vid = lfsr[9:5];
			for (int i = 0; i < 5; i++)
				if (lfsr[i])
					sr[i*8 +: 8] = 8'h05;
			pulse();
			expect_flags(exp_supply(lfsr[4:0]));
			rd_chk(FM_ADDR_VOLT_ID, {3'h0, vid});
		end
		// Fault arriving on the read edge must survive the clear
		fork
			rd_chk(FM_ADDR_STATUS_PRI, 8'h00);
			begin
				@(posedge clk);
				#1;
				sr[7:0] = 8'h05;
			end
		join
		rd_chk(FM_ADDR_STATUS_PRI, 8'h01);
		rd_chk(FM_ADDR_STATUS_PRI, 8'h01);
		quiet();
		rd_chk(FM_ADDR_STATUS_PRI, 8'h01);
		rd_chk(FM_ADDR_STATUS_PRI, 8'h00);
		sr[39:32] = 8'h05;
		pulse();
		for (int i = 0; i < 3; i++)
			u_fm_host_model.access(8'(FM_ADDR_STATUS_PRI + i), 1'b1, 8'hFF, i, d);
		expect_flags(16'h8001);
		rd_chk(FM_ADDR_VOLT_ID, {3'h0, vid});
		rd_chk(8'h50, FM_RST_RDATA);
		// Mid-run reset must wipe bits that are set
		b_open = 1'b1;
		pulse();
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rd_chk(FM_ADDR_STATUS_PRI, FM_RST_STATUS_PRI);
		rd_chk(FM_ADDR_STATUS_SEC, FM_RST_STATUS_SEC);
		final_report();
	end
endmodule // fm_fault_bank_tb_top

// ### tb/fm_host_model.sv
// Host side model: register reads and writes with one-cycle strobes.
// Assumes read data is valid one cycle after the strobe edge.
`timescale 1ns/1ns
module fm_host_model (
	// Clock
	input wire logic i_ref_clk,
	// Register port
	output logic [7:0] o_reg_addr,
	output logic o_reg_rd,
	output logic o_reg_wr,
	output logic [7:0] o_reg_wdata,
	input wire logic [7:0] i_reg_rdata
);
	initial
	begin
		o_reg_addr = 8'h00;
		o_reg_rd = 1'b0;
		o_reg_wr = 1'b0;
		o_reg_wdata = 8'h00;
	end
	// Idle cycles model a slow poller; released address and write data lines show inverse values, strobes drop to zero
	task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] wd,
		input int idle, output logic [7:0] d);
		repeat (idle) @(posedge i_ref_clk);
		@(posedge i_ref_clk);
		#1;
		o_reg_addr = a;
		o_reg_rd = !wr;
		o_reg_wr = wr;
		o_reg_wdata = wd;
		@(posedge i_ref_clk);
		#1;
		d = i_reg_rdata;
		o_reg_rd = 1'b0;
		o_reg_wr = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~wd;
	endtask
endmodule // fm_host_model
